/* File: bench/dwp_host.sv */
// host board model driving the module bus
`timescale 1ns/1ps
module dwp_host (
   input wire logic clock,
   output dwp_pkg::dwp_addr_t module_addr,
   output logic module_chip_select_first_n,
   output logic io_read_n,
   output logic io_write_n,
   output dwp_pkg::dwp_byte_t data_in
);
   import dwp_pkg::*;
   // idle bus from time zero
   initial begin
      module_addr = 3'h7;
      module_chip_select_first_n = 1'b1;
      io_read_n = 1'b1;
      io_write_n = 1'b1;
      data_in = 8'h00;
   end
   task automatic cycle(input dwp_addr_t a, input dwp_byte_t d, input logic sel_n, input logic rd);
      repeat (3) @(negedge clock);
      module_addr = a;
      data_in = d;
      module_chip_select_first_n = sel_n;
      if (rd) io_read_n = 1'b0;
      else io_write_n = 1'b0;
      repeat (4) @(negedge clock);
      io_read_n = 1'b1;
      io_write_n = 1'b1;
      @(negedge clock);
      // released lines flip so a stale value cannot pass
      module_chip_select_first_n = 1'b1;
      module_addr = ~a;
      data_in = ~d;
   endtask : cycle
endmodule : dwp_host

/* File: bench/dwp_write_port_properties.sv */
// port checker for the converter write port
`timescale 1ns/1ps
module dwp_write_port_properties (
   input wire logic clock,
   input wire logic nrst,
   input wire dwp_pkg::dwp_addr_t module_addr,
   input wire logic module_chip_select_first_n,
   input wire logic io_read_n,
   input wire logic io_write_n,
   input wire dwp_pkg::dwp_byte_t data_in,
   input wire dwp_pkg::dwp_chan_t range_bipolar,
   input wire dwp_pkg::dwp_byte_t data_out,
   input wire logic data_oe_n,
   input wire logic dma_request,
   input wire dwp_pkg::dwp_code_t analog_out_channel_zero_code,
   input wire dwp_pkg::dwp_code_t analog_out_channel_one_code,
   input wire dwp_pkg::dwp_level_t analog_out_channel_zero_level,
   input wire dwp_pkg::dwp_level_t analog_out_channel_one_level,
   input wire logic update_done
);
   import dwp_pkg::*;
   dwp_byte_t pin_r [4];
   // ----
   // helpers
   // ----
   // raw pin copies; the design sees them two flops later, so they are settled by update time
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) pin_r[i] <= '0;
      end else if (!module_chip_select_first_n && !io_write_n && io_read_n && module_addr < 3'h4) begin
         pin_r[module_addr[1:0]] <= data_in;
      end
   end
   // expected level from a code and its range jumper
   function automatic dwp_level_t lvl(input dwp_code_t c, input logic b);
      return dwp_level_t'({1'b0, c}) - (b ? 13'h0800 : 13'h0000);
   endfunction : lvl
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // ----
   // properties
   // ----
   sequence s_wr3_low;
      (!module_chip_select_first_n && !io_write_n && io_read_n && module_addr == 3'h3) [*3];
   endsequence
   sequence s_wr3_done;
      s_wr3_low ##1 (io_write_n && !module_chip_select_first_n);
   endsequence
   property p_wr3_update;
      s_wr3_done |-> ##[3:5] update_done;
   endproperty
   property p_hold;
      (analog_out_channel_zero_code != $past(analog_out_channel_zero_code) ||
       analog_out_channel_one_code != $past(analog_out_channel_one_code)) |-> update_done;
   endproperty
   property p_code0_upd;
      update_done |-> analog_out_channel_zero_code == {pin_r[1][3:0], pin_r[0]};
   endproperty
   property p_code1_upd;
      update_done |-> analog_out_channel_one_code == {pin_r[3][3:0], pin_r[2]};
   endproperty
   property p_level0;
      $stable(range_bipolar) [*6] |->
         analog_out_channel_zero_level == lvl($past(analog_out_channel_zero_code), range_bipolar[0]);
   endproperty
   property p_level1;
      $stable(range_bipolar) [*6] |->
         analog_out_channel_one_level == lvl($past(analog_out_channel_one_code), range_bipolar[1]);
   endproperty
   property p_no_drive;
      data_oe_n && data_out == 8'h00;
   endproperty
   property p_no_dma;
      dma_request == 1'b0;
   endproperty
   a_wr3_update: assert property (p_wr3_update) else $error("no update after port 3 write");
   a_hold: assert property (p_hold) else $error("code moved without update");
   a_code0_upd: assert property (p_code0_upd) else $error("channel zero code wrong");
   a_code1_upd: assert property (p_code1_upd) else $error("channel one code wrong");
   a_level0: assert property (p_level0) else $error("channel zero level wrong");
   a_level1: assert property (p_level1) else $error("channel one level wrong");
   a_no_drive: assert property (p_no_drive) else $error("data bus driven");
   a_no_dma: assert property (p_no_dma) else $error("dma request raised");
endmodule : dwp_write_port_properties

bind dwp_write_port dwp_write_port_properties u_props (.clock(clock), .nrst(nrst), .module_addr(module_addr),
   .module_chip_select_first_n(module_chip_select_first_n), .io_read_n(io_read_n), .io_write_n(io_write_n),
   .data_in(data_in), .range_bipolar(range_bipolar), .data_out(data_out), .data_oe_n(data_oe_n),
   .dma_request(dma_request), .analog_out_channel_zero_code(analog_out_channel_zero_code),
   .analog_out_channel_one_code(analog_out_channel_one_code),
   .analog_out_channel_zero_level(analog_out_channel_zero_level),
   .analog_out_channel_one_level(analog_out_channel_one_level), .update_done(update_done));

/* File: bench/dwp_write_port_test.sv */
// self-checking bench for the converter write port
`timescale 1ns/1ps
module dwp_write_port_test;
   import dwp_pkg::*;
   logic clock, nrst, cs_n, rd_n, wr_n, oe_n, dma, upd, inc;
   dwp_addr_t addr;
   dwp_chan_t range_bipolar;
   dwp_byte_t din, dout;
   dwp_code_t code0, code1;
   dwp_level_t level0, level1;
   int n_fail, n_compared;
   dwp_host host (.clock(clock), .module_addr(addr), .module_chip_select_first_n(cs_n),
      .io_read_n(rd_n), .io_write_n(wr_n), .data_in(din));
   dwp_write_port dut (.clock(clock), .nrst(nrst), .module_addr(addr), .module_chip_select_first_n(cs_n),
      .io_read_n(rd_n), .io_write_n(wr_n), .data_in(din), .range_bipolar(range_bipolar), .data_out(dout),
      .data_oe_n(oe_n), .dma_request(dma), .analog_out_channel_zero_code(code0),
      .analog_out_channel_one_code(code1), .analog_out_channel_zero_level(level0),
      .analog_out_channel_one_level(level1), .update_done(upd), .incomplete_update(inc));
   // ----
   // tasks
   // ----
   // free-running 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // compare and count
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // verdict and end of run
   task automatic test_done;
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // port 3 write, then a bounded wait for the update pulse
   task automatic wr_upd(input dwp_byte_t d);
      int i;
      host.cycle(3'h3, d, 1'b0, 1'b0);
      for (i = 0; i < 12 && upd !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      if (i == 12) begin
         chk("update_done", 16'h0000, 16'h0001);
         test_done();
      end
      @(negedge clock);
   endtask : wr_upd
   // ----
   // sequence
   // ----
   initial begin
      n_fail = 0;
      n_compared = 0;
      nrst = 1'b0;
      range_bipolar = 2'b00;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      host.cycle(3'h0, 8'h5a, 1'b0, 1'b0);
      host.cycle(3'h1, 8'hf3, 1'b0, 1'b0);
      host.cycle(3'h2, 8'hc4, 1'b0, 1'b0);
      repeat (8) @(negedge clock);
      chk("code0_held", {4'h0, code0}, 16'h0000);
      chk("code1_held", {4'h0, code1}, 16'h0000);
      wr_upd(8'ha7);
      chk("code0", {4'h0, code0}, 16'h035a);
      chk("code1", {4'h0, code1}, 16'h07c4);
      chk("incomplete", {15'h0000, inc}, 16'h0000);
      host.cycle(3'h4, 8'hff, 1'b0, 1'b0);
      host.cycle(3'h0, 8'h11, 1'b1, 1'b0);
      host.cycle(3'h0, 8'h22, 1'b0, 1'b1);
      wr_upd(8'hf1);
      chk("code0_kept", {4'h0, code0}, 16'h035a);
      chk("code1_new", {4'h0, code1}, 16'h01c4);
      chk("incomplete", {15'h0000, inc}, 16'h0001);
      chk("data_oe_n", {15'h0000, oe_n}, 16'h0001);
      chk("data_out", {8'h00, dout}, 16'h0000);
      chk("dma", {15'h0000, dma}, 16'h0000);
      range_bipolar = 2'b01;
      repeat (8) @(negedge clock);
      chk("level0_bip", {3'h0, level0[12:0]}, 16'h1b5a);
      chk("level1_uni", {3'h0, level1[12:0]}, 16'h01c4);
      range_bipolar = 2'b10;
      repeat (8) @(negedge clock);
      chk("level0_uni", {3'h0, level0[12:0]}, 16'h035a);
      chk("level1_bip", {3'h0, level1[12:0]}, 16'h19c4);
      test_done();
   end
endmodule : dwp_write_port_test

/* File: logic/dwp_channel.sv */
// one output channel: input latch, converter register, level
`timescale 1ns/1ps
`include "dwp_defs.svh"
module dwp_channel (
   input wire logic clock,
   input wire logic nrst,
   input wire logic load_low,
   input wire logic load_high,
   input wire logic update,
   input wire logic bipolar,
   input wire dwp_pkg::dwp_byte_t wr_byte,
   output dwp_pkg::dwp_code_t code,
   output dwp_pkg::dwp_level_t level
);
   import dwp_pkg::*;

   typedef struct packed {
      dwp_code_t in_latch;
      dwp_code_t conv_code;
      dwp_level_t level;
   } dwp_chan_state_t;

   dwp_chan_state_t st_r;
   dwp_chan_state_t st_nxt;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      // R3 low byte load
      // R5 low byte load
      if (load_low) begin
         st_nxt.in_latch[`DWP_BYTE_W-1:0] = wr_byte;
      end
      // R4 high nibble only
      // R6 upper bits dropped
      if (load_high) begin
         st_nxt.in_latch[`DWP_CODE_W-1:`DWP_BYTE_W] = wr_byte[`DWP_NIB_W-1:0];
      end
      // R7 take latest latch
      // R8 hold until update
      if (update) begin
         st_nxt.conv_code = st_nxt.in_latch;
      end
      // R9 straight or offset binary
      if (bipolar) begin
         st_nxt.level = dwp_level_t'({1'b0, st_r.conv_code}) - dwp_level_t'(`DWP_MIDSCALE);
      end else begin
         st_nxt.level = dwp_level_t'({1'b0, st_r.conv_code});
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r <= {`DWP_CODE_RST, `DWP_CODE_RST, `DWP_LEVEL_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign code = st_r.conv_code;
   assign level = st_r.level;
endmodule : dwp_channel

/* File: logic/dwp_sync.sv */
// two-stage synchroniser for the bus pins and range jumpers
`timescale 1ns/1ps
`include "dwp_defs.svh"
module dwp_sync (
   input wire logic clock,
   input wire logic nrst,
   input wire dwp_pkg::dwp_sync_t async_in,
   output dwp_pkg::dwp_sync_t sync_out
);
   import dwp_pkg::*;

   typedef struct packed {
      dwp_sync_t stage1;
      dwp_sync_t stage2;
   } dwp_sync_state_t;

   dwp_sync_state_t st_r;
   dwp_sync_state_t st_nxt;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // first stage feeds only the second stage
   always_comb begin
      st_nxt = st_r;
      st_nxt.stage1 = async_in;
      st_nxt.stage2 = st_r.stage1;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // reset to all ones so strobes and selects read idle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r <= {`DWP_SYNC_RST, `DWP_SYNC_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stage2;
endmodule : dwp_sync

/* File: logic/dwp_write_port.sv */
// byte-wide write port for a two-channel 12-bit output converter
//
// Operation
// R1 - decode three address lines, first select
// R2 - byte-wide I/O cycles only
// R3 - port 0 loads channel zero low
// R4 - port 1 loads channel zero bits 11-8
// R5 - port 2 loads channel one low
// R6 - port 3 loads channel one bits 11-8
// R7 - port 3 write updates both together
// R8 - converter codes hold until next update
// R9 - unipolar straight, bipolar offset binary
// R10 - never request or acknowledge DMA
// R11 - host writes port 3 last
`timescale 1ns/1ps
`include "dwp_defs.svh"
module dwp_write_port (
   input wire logic clock,
   input wire logic nrst,
   input wire dwp_pkg::dwp_addr_t module_addr,
   input wire logic module_chip_select_first_n,
   input wire logic io_read_n,
   input wire logic io_write_n,
   input wire dwp_pkg::dwp_byte_t data_in,
   input wire dwp_pkg::dwp_chan_t range_bipolar,
   output dwp_pkg::dwp_byte_t data_out,
   output logic data_oe_n,
   output logic dma_request,
   output dwp_pkg::dwp_code_t analog_out_channel_zero_code,
   output dwp_pkg::dwp_code_t analog_out_channel_one_code,
   output dwp_pkg::dwp_level_t analog_out_channel_zero_level,
   output dwp_pkg::dwp_level_t analog_out_channel_one_level,
   output logic update_done,
   output logic incomplete_update
);
   import dwp_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      dwp_bus_state_t bus_st;
      dwp_addr_t addr_cap;
      dwp_byte_t data_cap;
      dwp_byte_t wr_byte;
      dwp_chan_t load_low;
      dwp_chan_t load_high;
      logic update;
      logic [2:0] seen;
      logic update_done;
      logic incomplete;
      dwp_byte_t data_out;
      logic data_oe_n;
      logic dma_request;
   } dwp_port_state_t;

   dwp_port_state_t st_r;
   dwp_port_state_t st_nxt;

   // synchronised pins
   dwp_sync_t pins_async;
   dwp_sync_t pins_sync;
   dwp_addr_t s_addr;
   dwp_byte_t s_data;
   dwp_chan_t s_bipolar;
   logic s_cs_n;
   logic s_wr_n;
   logic s_rd_n;
   logic wr_cycle;
   logic rd_cycle;
   dwp_sel_t cap_sel;

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   // every pin crosses two flops; the host strobes are asynchronous
   assign pins_async = {
      module_chip_select_first_n,
      io_write_n,
      io_read_n,
      module_addr,
      data_in,
      range_bipolar
   };

   dwp_sync u_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   // unpack the synchronised bundle
   assign {s_cs_n, s_wr_n, s_rd_n, s_addr, s_data, s_bipolar} = pins_sync;

   // R1 first select only
   // R2 strobe-qualified cycles
   assign wr_cycle = !s_cs_n && !s_wr_n && s_rd_n;
   assign rd_cycle = !s_cs_n && !s_rd_n && s_wr_n;

   // R1 ports zero to three
   assign cap_sel = dwp_decode(st_r.addr_cap);

   // ----------------------------------------
   // bus state machine
   // ----------------------------------------
   // a write is committed on the trailing edge of the write strobe,
   // so address and data are taken from the last sample taken with select low while the strobe is low
   always_comb begin
      st_nxt = st_r;
      st_nxt.load_low = '0;
      st_nxt.load_high = '0;
      st_nxt.update = 1'b0;
      st_nxt.update_done = 1'b0;
      // R10 no DMA request
      st_nxt.dma_request = 1'b0;
      // write-only port: the data bus is never driven
      st_nxt.data_oe_n = 1'b1;
      st_nxt.data_out = `DWP_BYTE_RST;
      unique case (st_r.bus_st)
         DWP_IDLE: begin
            if (!s_wr_n && !s_rd_n) begin
               st_nxt.bus_st = DWP_WAIT_QUIET;
            end else if (wr_cycle) begin
               st_nxt.addr_cap = s_addr;
               st_nxt.data_cap = s_data;
               st_nxt.bus_st = DWP_WR_HOLD;
            end else if (rd_cycle) begin
               st_nxt.bus_st = DWP_RD_HOLD;
            end
         end
         DWP_WR_HOLD: begin
            if (!s_rd_n) begin
               // read strobe low during a write is a broken cycle: drop it
               st_nxt.bus_st = DWP_WAIT_QUIET;
            end else if (!s_wr_n) begin
               // keep sampling; the host data settles during the strobe
               if (!s_cs_n) begin
                  st_nxt.addr_cap = s_addr;
                  st_nxt.data_cap = s_data;
               end
            end else begin
               st_nxt.wr_byte = st_r.data_cap;
               // R3 channel zero low
               st_nxt.load_low[0] = cap_sel[`DWP_SEL_OUT0_LOW];
               // R4 channel zero high
               st_nxt.load_high[0] = cap_sel[`DWP_SEL_OUT0_HIGH];
               // R5 channel one low
               st_nxt.load_low[1] = cap_sel[`DWP_SEL_OUT1_LOW];
               // R6 channel one high
               st_nxt.load_high[1] = cap_sel[`DWP_SEL_OUT1_HIGH_UPD];
               // R7 update both channels
               st_nxt.update = cap_sel[`DWP_SEL_OUT1_HIGH_UPD];
               st_nxt.bus_st = DWP_IDLE;
            end
         end
         DWP_RD_HOLD: begin
            // R2 reads are not answered
            if (!s_wr_n) begin
               st_nxt.bus_st = DWP_WAIT_QUIET;
            end else if (s_rd_n) begin
               st_nxt.bus_st = DWP_IDLE;
            end
         end
         DWP_WAIT_QUIET: begin
            if (s_wr_n && s_rd_n) begin
               st_nxt.bus_st = DWP_IDLE;
            end
         end
      endcase

      // ----------------------------------------
      // write-order tracking
      // ----------------------------------------
      // R11 order check
      if (st_r.update) begin
         st_nxt.update_done = 1'b1;
         st_nxt.incomplete = (st_r.seen != `DWP_SEEN_ALL);
         st_nxt.seen = `DWP_SEEN_RST;
      end else begin
         if (st_r.load_low[0]) begin
            st_nxt.seen[0] = 1'b1;
         end
         if (st_r.load_high[0]) begin
            st_nxt.seen[1] = 1'b1;
         end
         if (st_r.load_low[1]) begin
            st_nxt.seen[2] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r.bus_st <= DWP_IDLE;
         st_r.addr_cap <= `DWP_OFS_OUT0_LOW;
         st_r.data_cap <= `DWP_BYTE_RST;
         st_r.wr_byte <= `DWP_BYTE_RST;
         st_r.load_low <= '0;
         st_r.load_high <= '0;
         st_r.update <= 1'b0;
         st_r.seen <= `DWP_SEEN_RST;
         st_r.update_done <= 1'b0;
         st_r.incomplete <= 1'b0;
         st_r.data_out <= `DWP_BYTE_RST;
         st_r.data_oe_n <= 1'b1;
         st_r.dma_request <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // output channels
   // ----------------------------------------
   dwp_code_t ch_code [`DWP_NUM_CH];
   dwp_level_t ch_level [`DWP_NUM_CH];

   // one latch pair per channel; update is shared so both move together
   genvar gi;
   generate
      for (gi = 0; gi < `DWP_NUM_CH; gi++) begin : g_chan
         dwp_channel u_chan (
            .clock(clock),
            .nrst(nrst),
            .load_low(st_r.load_low[gi]),
            .load_high(st_r.load_high[gi]),
            // R7 single shared update
            .update(st_r.update),
            .bipolar(s_bipolar[gi]),
            .wr_byte(st_r.wr_byte),
            .code(ch_code[gi]),
            .level(ch_level[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // all straight from flops inside this module or the channels
   assign analog_out_channel_zero_code = ch_code[0];
   assign analog_out_channel_one_code = ch_code[1];
   assign analog_out_channel_zero_level = ch_level[0];
   assign analog_out_channel_one_level = ch_level[1];
   assign update_done = st_r.update_done;
   assign incomplete_update = st_r.incomplete;
   assign data_out = st_r.data_out;
   assign data_oe_n = st_r.data_oe_n;
   // R10 held inactive
   assign dma_request = st_r.dma_request;
endmodule : dwp_write_port

/* File: pkg/dwp_defs.svh */
// constants for the two-channel converter write port
`ifndef DWP_DEFS_SVH
`define DWP_DEFS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define DWP_CODE_W 12
`define DWP_BYTE_W 8
`define DWP_NIB_W 4
`define DWP_ADDR_W 3
`define DWP_NUM_PORTS 4
`define DWP_NUM_CH 2
`define DWP_SYNC_W 16
// ----------------------------------------
// port offsets and decode
// ----------------------------------------
`define DWP_OFS_OUT0_LOW 3'h0
`define DWP_OFS_OUT0_HIGH 3'h1
`define DWP_OFS_OUT1_LOW 3'h2
`define DWP_OFS_OUT1_HIGH_UPD 3'h3
`define DWP_SEL_OUT0_LOW 0
`define DWP_SEL_OUT0_HIGH 1
`define DWP_SEL_OUT1_LOW 2
`define DWP_SEL_OUT1_HIGH_UPD 3
// ----------------------------------------
// reset values and coding
// ----------------------------------------
`define DWP_CODE_RST 12'h000
`define DWP_LEVEL_RST 13'h0000
`define DWP_MIDSCALE 13'h0800
`define DWP_BYTE_RST 8'h00
`define DWP_SEEN_RST 3'h0
`define DWP_SEEN_ALL 3'h7
`define DWP_SYNC_RST 16'hffff
`endif

/* File: pkg/dwp_pkg.sv */
// types and decode helper for the converter write port
package dwp_pkg;
`include "dwp_defs.svh"

   typedef logic [`DWP_CODE_W-1:0] dwp_code_t;
   typedef logic signed [`DWP_CODE_W:0] dwp_level_t;
   typedef logic [`DWP_BYTE_W-1:0] dwp_byte_t;
   typedef logic [`DWP_ADDR_W-1:0] dwp_addr_t;
   typedef logic [`DWP_NUM_PORTS-1:0] dwp_sel_t;
   typedef logic [`DWP_NUM_CH-1:0] dwp_chan_t;
   typedef logic [`DWP_SYNC_W-1:0] dwp_sync_t;

   typedef enum logic [1:0] {
      DWP_IDLE,
      DWP_WR_HOLD,
      DWP_RD_HOLD,
      DWP_WAIT_QUIET
   } dwp_bus_state_t;

   // one-hot port select; offsets 4..7 select nothing
   function automatic dwp_sel_t dwp_decode(input dwp_addr_t a);
      dwp_sel_t s;
      s = '0;
      unique case (a)
         `DWP_OFS_OUT0_LOW: s[`DWP_SEL_OUT0_LOW] = 1'b1;
         `DWP_OFS_OUT0_HIGH: s[`DWP_SEL_OUT0_HIGH] = 1'b1;
         `DWP_OFS_OUT1_LOW: s[`DWP_SEL_OUT1_LOW] = 1'b1;
         `DWP_OFS_OUT1_HIGH_UPD: s[`DWP_SEL_OUT1_HIGH_UPD] = 1'b1;
         default: s = '0;
      endcase
      return s;
   endfunction : dwp_decode
endpackage : dwp_pkg
